// File: hw/taf_alarm_queue.sv
// Module: APB register file, conversion timer and alarm fault queue
`timescale 1ns/1ps
module taf_alarm_queue #(
    parameter int CONV_CYCLES = taf_pkg::CONV_CYCLES, // Cycles per conversion
    parameter int TEMP_BITS = 12 // Valid result bits, from the top
) (
    input wire logic pclk, // 125 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire taf_pkg::taf_apb_req_t apb_req, // APB request group
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [15:0] adc_data, // Converter result, left aligned
    output logic adc_enable, // Converter powered
    output logic temp_alarm_out // Alarm pin level
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Fault queue depth from the two depth bits
    function automatic logic [2:0] depth_of(input logic [1:0] code);
        case (code)
            2'd0: depth_of = 3'd1;
            2'd1: depth_of = 3'd2;
            2'd2: depth_of = 3'd4;
            default: depth_of = 3'd6;
        endcase
    endfunction

    // Address is one of the four words
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == taf_pkg::OFS_TEMP) || (a == taf_pkg::OFS_CFG)
            || (a == taf_pkg::OFS_LOW) || (a == taf_pkg::OFS_HIGH);
    endfunction

    // Top bits at limit resolution, signed
    function automatic logic signed [taf_pkg::LIM_BITS-1:0] lim(input logic [15:0] v);
        lim = v[15:taf_pkg::LIM_LSB];
    endfunction

    localparam logic [15:0] TEMP_MASK = 16'hffff << (16 - TEMP_BITS);
    localparam logic [15:0] LIM_MASK = 16'hffff << taf_pkg::LIM_LSB;

    taf_pkg::taf_state_t st_r;
    taf_pkg::taf_state_t st_nxt;
    logic rd_acc;
    logic wr_acc;
    logic setup;
    logic wr_clr;
    logic conv_go;
    logic hi_flt;
    logic lo_flt;
    logic qual;
    logic [2:0] depth;

    // Bus phase decode
    assign setup = apb_req.psel && !apb_req.penable;
    assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // All decisions are made in one pass so a read clear and a conversion
    // in the same cycle are both honoured, in that order.
    always_comb begin
        st_nxt = st_r;
        wr_clr = 1'b0;
        conv_go = 1'b0;
        hi_flt = 1'b0;
        lo_flt = 1'b0;
        qual = 1'b0;
        depth = 3'd1;
        if (ce) begin
            // Read data registered in setup so it stands the whole access
            if (setup) begin
                case (apb_req.paddr)
                    taf_pkg::OFS_TEMP: st_nxt.prdata = {16'h0000, st_r.temp};
                    taf_pkg::OFS_CFG: st_nxt.prdata = {27'h0, st_r.cfg};
                    taf_pkg::OFS_LOW: st_nxt.prdata = {16'h0000, st_r.low};
                    taf_pkg::OFS_HIGH: st_nxt.prdata = {16'h0000, st_r.high};
                    default: st_nxt.prdata = 32'h0;
                endcase
            end
            // Writes; the result register is read only
            if (wr_acc) begin
                case (apb_req.paddr)
                    taf_pkg::OFS_CFG: begin
                        st_nxt.cfg = apb_req.pwdata[taf_pkg::CFG_W-1:0]; // R16 R17 R18
                        wr_clr = 1'b1; // R5
                    end
                    taf_pkg::OFS_LOW: begin
                        st_nxt.low = apb_req.pwdata[15:0] & LIM_MASK;
                        wr_clr = 1'b1; // R5
                    end
                    taf_pkg::OFS_HIGH: begin
                        st_nxt.high = apb_req.pwdata[15:0] & LIM_MASK;
                        wr_clr = 1'b1; // R5
                    end
                    default: wr_clr = 1'b0;
                endcase
            end
            depth = depth_of(st_nxt.cfg[taf_pkg::CFG_DEPTH_LO +: 2]); // R3
            // Conversion timer; restarts from zero on leaving shutdown
            if (st_nxt.cfg[taf_pkg::CFG_SHDN]) begin
                st_nxt.tmr = '0; // R13
                st_nxt.temp = taf_pkg::TEMP_RST; // R13
            end else if (st_r.tmr == taf_pkg::TMR_W'(CONV_CYCLES - 1)) begin
                st_nxt.tmr = '0;
                conv_go = 1'b1; // R19
                st_nxt.temp = adc_data & TEMP_MASK; // R14
            end else begin
                st_nxt.tmr = st_r.tmr + 1'b1;
            end
            // Compare the fresh result at limit resolution
            hi_flt = lim(st_nxt.temp) > lim(st_nxt.high); // R2 R20
            lo_flt = lim(st_nxt.temp) < lim(st_nxt.low); // R2 R20
            if (wr_clr || st_nxt.cfg[taf_pkg::CFG_SHDN]) begin
                // Clearing the queue also drops the alarm and rearms high
                st_nxt.cnt = 3'd0; // R5 R15
                st_nxt.alarm = 1'b0; // R6
                st_nxt.look_low = 1'b0; // R9
            end else begin
                // Any register read releases a latched alarm
                if (rd_acc && st_r.alarm && st_r.cfg[taf_pkg::CFG_MODE]) begin
                    st_nxt.alarm = 1'b0; // R11
                    st_nxt.look_low = !st_r.look_low; // R10 R11
                    st_nxt.cnt = 3'd0;
                end
                if (conv_go && !(st_nxt.alarm && st_nxt.cfg[taf_pkg::CFG_MODE])) begin
                    if (st_nxt.cfg[taf_pkg::CFG_MODE]) begin
                        qual = st_nxt.look_low ? lo_flt : hi_flt; // R12
                    end else begin
                        qual = st_nxt.alarm ? lo_flt : hi_flt; // R7 R8
                    end
                    if (!qual) begin
                        st_nxt.cnt = 3'd0; // R4
                    end else if (st_nxt.cnt + 3'd1 >= depth) begin
                        st_nxt.alarm = !st_nxt.alarm; // R1 R7 R8 R12
                        st_nxt.cnt = 3'd0;
                    end else begin
                        st_nxt.cnt = st_nxt.cnt + 3'd1; // R1
                    end
                end
            end
            // Pin level follows the alarm in the same cycle
            st_nxt.out = st_nxt.cfg[taf_pkg::CFG_POL] ? st_nxt.alarm : !st_nxt.alarm; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Reset puts the limits at their defaults and the pin inactive-low-high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.temp <= taf_pkg::TEMP_RST;
            st_r.high <= taf_pkg::HIGH_RST;
            st_r.low <= taf_pkg::LOW_RST;
            st_r.cfg <= taf_pkg::CFG_RST;
            st_r.tmr <= '0;
            st_r.cnt <= 3'd0; // R5
            st_r.alarm <= 1'b0;
            st_r.look_low <= 1'b0;
            st_r.out <= 1'b1;
            st_r.prdata <= 32'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero wait state slave; bad addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = apb_req.psel && apb_req.penable && !addr_hit(apb_req.paddr);
    assign prdata = st_r.prdata;
    assign adc_enable = !st_r.cfg[taf_pkg::CFG_SHDN]; // R13
    assign temp_alarm_out = st_r.out;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_shdn_temp: assert property ( // R13
        ce && st_nxt.cfg[taf_pkg::CFG_SHDN] |=> st_r.temp == 16'h8000
    ) else $error("Result not forced in shutdown");

    chk_shdn_queue: assert property ( // R15
        st_r.cfg[taf_pkg::CFG_SHDN] |-> st_r.cnt == 3'd0 && !st_r.alarm
    ) else $error("Queue active in shutdown");

    chk_write_clear: assert property ( // R5
        ce && wr_acc && addr_hit(apb_req.paddr) && apb_req.paddr != taf_pkg::OFS_TEMP
        |=> st_r.cnt == 3'd0 && !st_r.alarm && !st_r.look_low
    ) else $error("Write did not clear queue");

    chk_pol_out: assert property ( // R16
        $rose(st_r.alarm) |-> temp_alarm_out == st_r.cfg[taf_pkg::CFG_POL]
    ) else $error("Alarm pin polarity wrong");

    chk_read_release: assert property ( // R11
        ce && rd_acc && st_r.alarm && st_r.cfg[taf_pkg::CFG_MODE] && !conv_go
        && !st_nxt.cfg[taf_pkg::CFG_SHDN]
        |=> !st_r.alarm && st_r.look_low != $past(st_r.look_low)
    ) else $error("Read did not release latched alarm");

    chk_tol_clear: assert property ( // R4
        ce && conv_go && !st_r.alarm && !hi_flt && !lo_flt |=> st_r.cnt == 3'd0
    ) else $error("In-tolerance result kept count");

    chk_cmp_assert: assert property ( // R7
        ce && conv_go && !wr_clr && !st_r.cfg[taf_pkg::CFG_MODE] && !st_r.alarm
        && hi_flt && st_r.cnt + 3'd1 == depth |=> st_r.alarm
    ) else $error("Comparator alarm missed at depth");

    chk_latch_hold: assert property ( // R11
        st_r.alarm && st_r.cfg[taf_pkg::CFG_MODE] && !(rd_acc && ce) && !wr_clr
        && !st_nxt.cfg[taf_pkg::CFG_SHDN] |=> st_r.alarm
    ) else $error("Latched alarm dropped without read");

    chk_cnt_bound: assert property ( // R3
        st_r.cnt < depth_of(st_r.cfg[taf_pkg::CFG_DEPTH_LO +: 2])
    ) else $error("Fault count beyond depth");

    chk_conv_run: assert property ( // R19
        conv_go |-> !st_r.cfg[taf_pkg::CFG_SHDN] && ce
    ) else $error("Conversion taken in shutdown");

    ////////////////////////////////////////////////////////////////////////////
    // Queue, pin and timer checks

    // The pin must always be the alarm seen through the polarity bit
    chk_pin_level: assert property ( // R16
        temp_alarm_out == (st_r.cfg[taf_pkg::CFG_POL] ? st_r.alarm : !st_r.alarm)
    ) else $error("Alarm pin does not follow alarm state");

    // The alarm may only rise on a conversion, never on a bus access
    chk_alarm_source: assert property ( // R1
        $rose(st_r.alarm) |-> $past(conv_go)
    ) else $error("Alarm raised without a conversion");

    // The fault count moves only on conversions, clears or read releases
    chk_cnt_hold: assert property ( // R1
        ce && !conv_go && !wr_clr && !st_nxt.cfg[taf_pkg::CFG_SHDN]
        && !(rd_acc && st_r.alarm && st_r.cfg[taf_pkg::CFG_MODE])
        |=> st_r.cnt == $past(st_r.cnt)
    ) else $error("Fault count moved without a conversion");

    // Comparator mode drops the alarm after the full run of low results
    chk_cmp_release: assert property ( // R8
        ce && conv_go && !wr_clr && !st_r.cfg[taf_pkg::CFG_MODE] && st_r.alarm
        && lo_flt && st_r.cnt + 3'd1 == depth |=> !st_r.alarm
    ) else $error("Comparator alarm not released at depth");

    // Interrupt mode raises on the watched fault type at full depth
    chk_int_assert: assert property ( // R12
        ce && conv_go && !wr_clr && st_r.cfg[taf_pkg::CFG_MODE] && !st_r.alarm
        && (st_r.look_low ? lo_flt : hi_flt) && st_r.cnt + 3'd1 == depth
        |=> st_r.alarm
    ) else $error("Interrupt alarm missed at depth");

    // A latched alarm ignores further conversions until it is read
    chk_int_ignore: assert property ( // R11
        ce && conv_go && st_r.alarm && st_r.cfg[taf_pkg::CFG_MODE] && !rd_acc && !wr_clr
        |=> st_r.alarm && st_r.cnt == $past(st_r.cnt)
    ) else $error("Latched alarm disturbed by a conversion");

    // Entering shutdown leaves the pin at its inactive level
    chk_shdn_pin: assert property ( // R6
        ce && st_nxt.cfg[taf_pkg::CFG_SHDN] |=> temp_alarm_out == !st_r.cfg[taf_pkg::CFG_POL]
    ) else $error("Pin active in shutdown");

    // The timer idles at zero in shutdown so the first result is a full period away
    chk_shdn_timer: assert property ( // R15
        st_r.cfg[taf_pkg::CFG_SHDN] |-> st_r.tmr == '0 && !conv_go
    ) else $error("Timer running in shutdown");

    // The timer never passes its terminal count
    chk_tmr_bound: assert property ( // R19
        st_r.tmr < taf_pkg::TMR_W'(CONV_CYCLES)
    ) else $error("Conversion timer out of range");

    ////////////////////////////////////////////////////////////////////////////
    // Register checks

    // Configuration writes land whole in the stored field
    chk_wr_cfg: assert property ( // R17
        ce && wr_acc && apb_req.paddr == taf_pkg::OFS_CFG
        |=> st_r.cfg == $past(apb_req.pwdata[taf_pkg::CFG_W-1:0])
    ) else $error("Configuration write lost");

    // Limit writes keep only the bits at limit resolution
    chk_wr_low: assert property ( // R20
        ce && wr_acc && apb_req.paddr == taf_pkg::OFS_LOW
        |=> st_r.low == ($past(apb_req.pwdata[15:0]) & LIM_MASK)
    ) else $error("Low limit write lost");

    chk_wr_high: assert property ( // R20
        ce && wr_acc && apb_req.paddr == taf_pkg::OFS_HIGH
        |=> st_r.high == ($past(apb_req.pwdata[15:0]) & LIM_MASK)
    ) else $error("High limit write lost");

    // Stored limits never hold bits below their resolution
    chk_limit_mask: assert property ( // R20
        ((st_r.high | st_r.low) & ~LIM_MASK) == 16'h0000
    ) else $error("Limit holds bits below resolution");

    // The result never holds bits below the converter resolution
    chk_temp_mask: assert property ( // R14
        (st_r.temp & ~TEMP_MASK) == 16'h0000
    ) else $error("Result holds bits below resolution");

    // Read data is captured in setup so it stands through the access
    chk_setup_load: assert property ( // R14
        ce && setup && apb_req.paddr == taf_pkg::OFS_TEMP
        |=> prdata == {16'h0000, $past(st_r.temp)}
    ) else $error("Result read data not loaded in setup");

    // Unmapped reads return zero
    chk_err_read: assert property (
        ce && setup && !addr_hit(apb_req.paddr) |=> prdata == 32'h0
    ) else $error("Unmapped read returned data");

    // No register is wider than sixteen bits
    chk_prdata_upper: assert property (
        prdata[31:16] == 16'h0000
    ) else $error("Read data upper half not zero");

    // A low clock enable freezes every state bit
    chk_ce_freeze: assert property (
        !ce |=> st_r == $past(st_r)
    ) else $error("State moved while clock enable low");

    cov_cmp_alarm: cover property (
        !st_r.cfg[taf_pkg::CFG_MODE] && $rose(st_r.alarm)
    );
    cov_int_release: cover property (rd_acc && ce && st_r.alarm && st_r.cfg[taf_pkg::CFG_MODE]);
    cov_low_fault: cover property (st_r.look_low && $rose(st_r.alarm));
    cov_shutdown: cover property ($fell(st_r.cfg[taf_pkg::CFG_SHDN]));
    cov_depth_six: cover property (
        st_r.cfg[taf_pkg::CFG_DEPTH_LO +: 2] == 2'b11 && $rose(st_r.alarm)
    );

endmodule // taf_alarm_queue

// File: pkg/taf_pkg.sv
// Package: constants, state and bus types of the temperature alarm fault queue
// Notes on behaviour
// [R1] Alarm output toggles only after the programmed count of consecutive faults.
// [R2] A result is out of tolerance above the high limit or below the low limit.
// [R3] Queue depth selects one, two, four or six; one after reset.
// [R4] In-tolerance result while alarm is inactive clears the fault count.
// [R5] Count clears at reset, in shutdown and on limit or configuration writes.
// [R6] Every count clear also deasserts the alarm at once.
// [R7] Comparator mode asserts when consecutive high faults reach the depth.
// [R8] Comparator mode deasserts when consecutive low results reach the depth.
// [R9] Interrupt mode watches for a high fault after any count clear.
// [R10] Interrupt mode alternates watched fault type after each properly cleared fault.
// [R11] Interrupt alarm holds until any register read, then watches opposite type.
// [R12] Interrupt mode high and low faults both need the full queue depth.
// [R13] Shutdown stops conversions and forces the result register to 8000h.
// [R14] After shutdown the result reads 8000h until the first new conversion.
// [R15] Fault count is held in reset for the whole shutdown time.
// [R16] Polarity bit zero gives active-low output, one gives active-high.
// [R17] Mode bit zero selects comparator, one selects latched interrupt mode.
// [R18] Shutdown bit zero is normal operation, one is shutdown.
// [R19] A new result is taken and evaluated every 133 ms outside shutdown.
// [R20] Results and limits compare as signed values at limit resolution.
package taf_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_TEMP = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_LOW = 8'h08;
    localparam logic [7:0] OFS_HIGH = 8'h0c;

    // Configuration field positions
    localparam int CFG_SHDN = 0;
    localparam int CFG_MODE = 1;
    localparam int CFG_POL = 2;
    localparam int CFG_DEPTH_LO = 3;
    localparam int CFG_W = 5;

    // Reset values
    localparam logic [15:0] TEMP_RST = 16'h8000;
    localparam logic [15:0] HIGH_RST = 16'h5000;
    localparam logic [15:0] LOW_RST = 16'h4b00;
    localparam logic [4:0] CFG_RST = 5'h00;

    // Limits keep only their top bits
    localparam int LIM_BITS = 9;
    localparam int LIM_LSB = 16 - LIM_BITS;

    // Conversion period
    localparam int CONV_TIME_MS = 133;
    localparam int CLK_MHZ = 125;
    localparam int CONV_CYCLES = CONV_TIME_MS * CLK_MHZ * 1000;
    localparam int TMR_W = 24;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } taf_apb_req_t;

    // Whole block state
    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] high;
        logic [15:0] low;
        logic [CFG_W-1:0] cfg;
        logic [TMR_W-1:0] tmr;
        logic [2:0] cnt;
        logic alarm;
        logic look_low;
        logic out;
        logic [31:0] prdata;
    } taf_state_t;

endpackage

// File: testbench/taf_adc_model.sv
// Converter model that feeds results to the alarm block
`timescale 1ns/1ps
module taf_adc_model (
    input wire logic pclk, // Bus clock
    input wire logic adc_enable, // Converter powered
    input wire logic [15:0] level, // Temperature code to present
    output logic [15:0] adc_data // Result bus toward the block
);
    logic [15:0] idle_r;

    // Powered down the bus toggles between the last code and its inverse, one cycle each
    always_ff @(posedge pclk) begin
        idle_r <= adc_enable ? ~level : ~idle_r;
    end

    // Live code only while powered
    assign adc_data = adc_enable ? level : idle_r;
endmodule // taf_adc_model

// File: testbench/tb.sv
// Self-checking testbench of the temperature alarm fault queue
`timescale 1ns/1ps
module tb;
    localparam int CONV = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    taf_pkg::taf_apb_req_t req = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] adc_data;
    logic adc_enable;
    logic temp_alarm_out;
    logic [15:0] level = 16'h4e00;
    logic [15:0] last = 16'h0000;
    logic [31:0] seed = 32'hb700b625;
    logic pol = 1'b0;
    logic ce = 1'b1;
    logic [32:0] expq[$];
    int miscompares = 0;
    int check_count = 0;
    int d;

    // Bus clock, 8 ns period
    always #4 pclk = ~pclk;

    // Short conversion period keeps the run brief
    taf_alarm_queue #(.CONV_CYCLES(CONV), .TEMP_BITS(12)) DUT (
        .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_data(adc_data),
        .adc_enable(adc_enable), .temp_alarm_out(temp_alarm_out));

    taf_adc_model adc (.pclk(pclk), .adc_enable(adc_enable), .level(level), .adc_data(adc_data));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // One APB transfer; the converter is parked in band so bus cycles add no faults
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        int n;
        @(posedge pclk);
        level <= 16'h4e00;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dt};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        req <= '0;
    endtask

    // Read with its expected error flag and data noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back({(a > 8'h0c || a[1:0] != 2'b00), e});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pin(input logic a);
        #1;
        check("alarm_pin", {32'h0, temp_alarm_out}, {32'h0, pol ? a : !a});
    endtask

    // n conversions of one kind: 0 in band, 1 above high, 2 below low
    task automatic cv(input int n, input int k);
        logic [15:0] v;
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            v = (k == 1) ? 16'h5100 + (seed[15:0] & 16'h0fff)
              : (k == 2) ? 16'h4000 + (seed[15:0] & 16'h0aff) : 16'h4e00 + (seed[15:0] & 16'h01ff);
            level <= v;
            last = v;
            repeat (CONV) @(posedge pclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watcher: every completed read takes the oldest note
    always @(posedge pclk) begin
        if (req.psel && req.penable && !req.pwrite && pready === 1'b1) begin
            if (expq.size() == 0) begin
                miscompares++;
                $display("[ERR] read_note exp queued seen %h", prdata);
            end else begin
                check("read", {pslverr, prdata}, expq.pop_front());
            end
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        pin(1'b0);
        rd(taf_pkg::OFS_TEMP, 32'h8000);
        rd(taf_pkg::OFS_CFG, 32'h0);
        rd(taf_pkg::OFS_LOW, 32'h4b00);
        rd(taf_pkg::OFS_HIGH, 32'h5000);
        rd(8'h10, 32'h0);
        apb(1'b1, taf_pkg::OFS_LOW, 32'h0000_4bff);
        rd(taf_pkg::OFS_LOW, 32'h4b80);
        // Comparator mode at every depth, polarity alternating
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 1 : (i == 1) ? 2 : (i == 2) ? 4 : 6;
            pol = i[0];
            apb(1'b1, taf_pkg::OFS_CFG, {27'h0, i[1:0], i[0], 2'b00});
            pin(1'b0);
            cv(d - 1, 1);
            pin(1'b0);
            cv(1, 0);
            cv(d - 1, 1);
            pin(1'b0);
            cv(1, 1);
            pin(1'b1);
            rd(taf_pkg::OFS_TEMP, {16'h0, last & 16'hfff0});
            cv(d - 1, 2);
            cv(1, 0);
            cv(d - 1, 2);
            pin(1'b1);
            cv(1, 2);
            pin(1'b0);
        end
        // A limit write drops a standing alarm
        pol = 1'b0;
        apb(1'b1, taf_pkg::OFS_CFG, 32'h0);
        cv(1, 1);
        pin(1'b1);
        apb(1'b1, taf_pkg::OFS_HIGH, 32'h0000_5000);
        pin(1'b0);
        // Latched mode, depth two
        apb(1'b1, taf_pkg::OFS_CFG, 32'h0000_000a);
        cv(1, 1);
        pin(1'b0);
        cv(1, 1);
        pin(1'b1);
        cv(1, 2);
        pin(1'b1);
        rd(taf_pkg::OFS_CFG, 32'h0a);
        pin(1'b0);
        cv(2, 1);
        pin(1'b0);
        cv(1, 2);
        pin(1'b0);
        cv(1, 2);
        pin(1'b1);
        rd(8'h10, 32'h0);
        pin(1'b0);
        cv(2, 1);
        pin(1'b1);
        rd(taf_pkg::OFS_TEMP, {16'h0, last & 16'hfff0});
        pin(1'b0);
        apb(1'b1, taf_pkg::OFS_CFG, 32'h0000_000a);
        cv(2, 2);
        pin(1'b0);
        cv(2, 1);
        pin(1'b1);
        // Shutdown entry and exit
        apb(1'b1, taf_pkg::OFS_CFG, 32'h0);
        cv(1, 1);
        pin(1'b1);
        apb(1'b1, taf_pkg::OFS_CFG, 32'h1);
        pin(1'b0);
        check("adc_enable", {32'h0, adc_enable}, 33'h0);
        rd(taf_pkg::OFS_TEMP, 32'h8000);
        cv(2, 1);
        pin(1'b0);
        apb(1'b1, taf_pkg::OFS_CFG, 32'h0);
        rd(taf_pkg::OFS_TEMP, 32'h8000);
        cv(1, 1);
        pin(1'b1);
        rd(taf_pkg::OFS_TEMP, {16'h0, last & 16'hfff0});
        check("adc_enable", {32'h0, adc_enable}, 33'h1);
        // A write with the clock enable low must leave the block untouched
        ce <= 1'b0;
        apb(1'b1, taf_pkg::OFS_CFG, 32'h1);
        ce <= 1'b1;
        pin(1'b1);
        check("adc_enable", {32'h0, adc_enable}, 33'h1);
        rd(taf_pkg::OFS_CFG, 32'h0);
        end_sim();
    end

    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
endmodule // tb
